//--- tec_thread_exception_control.sv
/*
 * Per-thread state and control words of one shader thread: masks, fault state
 * words, control word, exception enables and status, resume pointer and the
 * jump to the global handler entry.
 * Assumes the pipeline presents one operand access per cycle, pulses events
 * on the execution clock, and holds issue until the cycle after a load.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tec_map.svh"

module tec_thread_exception_control
    import tec_pkg::*;
(
    input wire logic ref_clk_i, // execution clock, 40 MHz
    input wire logic rstn_i, // async reset, active low
    input wire logic load_i, // thread load pulse
    input wire tec_dispatch_type disp_i, // dispatcher fields
    input wire tec_access_type acc_i, // operand access
    input wire logic [15:0] exc_event_i, // exception event pulses
    input wire logic [31:0] ip_i, // current instruction pointer
    input wire logic [47:0] handler_entry_i, // global handler entry
    input wire logic [4:0] fp_flag_i, // float exception pulses
    output logic [31:0] rd_data_o, // read data
    output logic rd_valid_o, // read data valid pulse
    output logic redirect_o, // fetch redirect pulse
    output logic [31:0] redirect_ip_o, // fetch target
    output logic [31:0] exec_mask_o, // execution mask in use
    output tec_fpctl_type fpctl_o, // decoded controls
    output logic exc_state_o, // thread in exception state
    output logic [3:0] top_pending_o, // highest pending status index
    output logic pending_o // any status bit pending
);

    logic [31:0] channel_dispatch_mask_reg; // channel dispatch mask
    logic [31:0] gmask_reg; // grouped channel mask
    logic [31:0] fault_reg [4]; // hardware fault state words
    logic [31:0] ctl_reg; // control word without master bit
    logic master_reg; // master exception state
    logic [15:0] enable_reg; // exception enables
    logic [15:0] status_reg; // exception status
    logic [31:0] resume_reg; // saved resume pointer
    logic [6:0] ieee_reg; // sticky float flags
    logic [31:0] rd_data_reg;
    logic rd_valid_reg;
    logic redirect_reg;
    logic [31:0] redirect_ip_reg;
    logic [31:0] exec_mask_reg;
    tec_fpctl_type fpctl_reg;
    logic [3:0] top_pending_reg;
    logic pending_reg;

    logic wr; // a write access this cycle
    logic sel_sr0; // state register 0 selected
    logic sel_sr1; // state register 1 selected
    logic sel_cr0; // control register selected
    logic take_exc; // an enabled exception is taken
    logic ret_exc; // software clears master bit
    logic [31:0] status_word; // control word 1 as read
    logic [31:0] ctl_word; // control word 0 as read
    logic [31:0] gmask_of_channel_dispatch_mask; // grouped form of the dispatch mask

    // grouped form: every bit of a nibble is the OR of that nibble
    function automatic logic [31:0] group_mask(input logic [31:0] m);
        logic [31:0] g;
        g = '0;
        for (int n = 0; n < 8; n++) begin
            g[n*4 +: 4] = {4{|m[n*4 +: 4]}};
        end
        return g;
    endfunction

    // operand decode; the pipeline keeps state operands coherent itself
    assign wr = acc_i.valid && acc_i.write;
    assign sel_sr0 = acc_i.reg_type == `TEC_RT_STATE && acc_i.reg_num == `TEC_RN_SR0;
    assign sel_sr1 = acc_i.reg_type == `TEC_RT_STATE && acc_i.reg_num == `TEC_RN_SR1;
    assign sel_cr0 = acc_i.reg_type == `TEC_RT_CTRL && acc_i.reg_num == `TEC_RN_CR0;
    assign gmask_of_channel_dispatch_mask = group_mask(disp_i.dispatch_mask);

    // exception taken only from normal state; events still record status
    // a thread load takes none, so a new thread never starts inside its handler
    assign take_exc = !master_reg && !load_i && |(exc_event_i & enable_reg);
    // return only when master is one and software writes zero
    assign ret_exc = wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W0
        && !acc_i.wdata[`TEC_CR_MASTER] && master_reg;

    assign ctl_word = {master_reg, ctl_reg[30:0]};
    assign status_word = {status_reg, enable_reg};

    // masks: loaded by the dispatcher, writable as operands
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            channel_dispatch_mask_reg <= `TEC_RST_WORD;
            gmask_reg <= `TEC_RST_WORD;
        end else if (load_i) begin
            channel_dispatch_mask_reg <= disp_i.dispatch_mask;
            gmask_reg <= gmask_of_channel_dispatch_mask;
        end else if (wr && sel_sr0) begin
            if (acc_i.sub_reg == `TEC_SUB_W2) begin
                channel_dispatch_mask_reg <= acc_i.wdata;
            end
            if (acc_i.sub_reg == `TEC_SUB_W3) begin
                gmask_reg <= acc_i.wdata;
            end
        end
    end

    // fault words survive thread load; only the handler saves and restores them
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int k = 0; k < 4; k++) begin
                fault_reg[k] <= `TEC_RST_WORD;
            end
        end else if (wr && sel_sr1) begin
            for (int k = 0; k < 4; k++) begin
                if (acc_i.sub_reg == 5'(k * 4)) begin
                    fault_reg[k] <= acc_i.wdata;
                end
            end
        end
    end

    // control word: load clears bits 12:9 and takes dispatcher fields
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_reg <= `TEC_RST_WORD;
        end else if (load_i) begin
            ctl_reg <= disp_i.ctl_init & `TEC_CR_LOADMASK;
        end else if (wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W0) begin
            ctl_reg <= acc_i.wdata & `TEC_CR_WMASK;
        end
    end

    // master bit: exception sets it, a write of one never does
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            master_reg <= 1'b0;
        end else if (load_i) begin
            master_reg <= 1'b0;
        end else if (take_exc) begin
            master_reg <= 1'b1;
        end else if (ret_exc) begin
            master_reg <= 1'b0;
        end
    end

    // enables and status; a new event wins over a clearing write
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enable_reg <= `TEC_RST_HALF;
            status_reg <= `TEC_RST_HALF;
        end else if (load_i) begin
            enable_reg <= disp_i.exc_enable;
            status_reg <= exc_event_i;
        end else if (wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W1) begin
            enable_reg <= acc_i.wdata[15:0];
            status_reg <= acc_i.wdata[31:16] | exc_event_i;
        end else begin
            status_reg <= status_reg | exc_event_i;
        end
    end

    // resume pointer captures the IP when an exception is taken
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resume_reg <= `TEC_RST_WORD;
        end else if (take_exc) begin
            resume_reg <= ip_i;
        end else if (load_i) begin
            resume_reg <= `TEC_RST_WORD;
        end else if (wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W2) begin
            resume_reg <= acc_i.wdata;
        end
    end

    // sticky float flags; trapping never redirects fetch
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ieee_reg <= `TEC_RST_IEEE;
        end else if (load_i) begin
            ieee_reg <= `TEC_RST_IEEE;
        end else begin
            if (wr && sel_sr0 && acc_i.sub_reg == `TEC_SUB_W1) begin
                ieee_reg <= (acc_i.wdata[6:0] & `TEC_IEEE_MASK)
                    | ({2'h0, fp_flag_i} & {`TEC_IEEE_W{ctl_reg[`TEC_CR_TRAP]}});
            end else if (ctl_reg[`TEC_CR_TRAP]) begin
                ieee_reg <= ieee_reg | {2'h0, fp_flag_i};
            end
        end
    end

    // fetch redirect: handler entry on exception, resume pointer on return
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            redirect_reg <= 1'b0;
            redirect_ip_reg <= `TEC_RST_WORD;
        end else begin
            redirect_reg <= take_exc || ret_exc;
            if (take_exc) begin
                redirect_ip_reg <= handler_entry_i[31:0];
            end else if (ret_exc) begin
                redirect_ip_reg <= resume_reg;
            end
        end
    end

    // read port; reserved words and unknown selectors read as zero
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_reg <= `TEC_RST_WORD;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= acc_i.valid && !acc_i.write;
            rd_data_reg <= `TEC_RST_WORD;
            if (acc_i.valid && !acc_i.write) begin
                if (sel_sr0) begin
                    unique case (acc_i.sub_reg)
                        `TEC_SUB_W1: rd_data_reg <= {25'h0, ieee_reg};
                        `TEC_SUB_W2: rd_data_reg <= channel_dispatch_mask_reg;
                        `TEC_SUB_W3: rd_data_reg <= gmask_reg;
                        default: rd_data_reg <= `TEC_RST_WORD;
                    endcase
                end else if (sel_sr1) begin
                    unique case (acc_i.sub_reg)
                        `TEC_SUB_W0: rd_data_reg <= fault_reg[0];
                        `TEC_SUB_W1: rd_data_reg <= fault_reg[1];
                        `TEC_SUB_W2: rd_data_reg <= fault_reg[2];
                        `TEC_SUB_W3: rd_data_reg <= fault_reg[3];
                        default: rd_data_reg <= `TEC_RST_WORD;
                    endcase
                end else if (sel_cr0) begin
                    unique case (acc_i.sub_reg)
                        `TEC_SUB_W0: rd_data_reg <= ctl_word;
                        `TEC_SUB_W1: rd_data_reg <= status_word;
                        `TEC_SUB_W2: rd_data_reg <= resume_reg;
                        default: rd_data_reg <= `TEC_RST_WORD;
                    endcase
                end
            end
        end
    end

    // execution mask chosen by mask select, one cycle behind the control word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exec_mask_reg <= `TEC_RST_WORD;
        end else if (ctl_reg[`TEC_CR_MSEL]) begin
            exec_mask_reg <= gmask_reg;
        end else begin
            exec_mask_reg <= channel_dispatch_mask_reg;
        end
    end

    // decoded float controls for the datapath
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fpctl_reg <= '0;
        end else begin
            fpctl_reg.alternative_float_mode <= ctl_reg[`TEC_CR_ALT];
            // alternative mode always flushes single-precision denormals
            fpctl_reg.sp_denorm_allow <= ctl_reg[`TEC_CR_SPDEN] && !ctl_reg[`TEC_CR_ALT];
            fpctl_reg.dp_denorm_allow <= ctl_reg[`TEC_CR_DPDEN];
            fpctl_reg.half_float_denorm_allow <= ctl_reg[`TEC_CR_HFDEN];
            fpctl_reg.round_mode <= tec_round_type'(ctl_reg[`TEC_CR_RND_HI:`TEC_CR_RND_LO]);
            fpctl_reg.f2i_round_mode <= ctl_reg[`TEC_CR_F2I]
                ? tec_round_type'(ctl_reg[`TEC_CR_RND_HI:`TEC_CR_RND_LO])
                : TEC_ROUND_TOWARD_ZERO;
            fpctl_reg.snan_minmax <= ctl_reg[`TEC_CR_MINMAX];
            fpctl_reg.ieee_trap_en <= ctl_reg[`TEC_CR_TRAP];
            fpctl_reg.acc_disable <= ctl_reg[`TEC_CR_ACCDIS];
            fpctl_reg.single_flow <= ctl_reg[`TEC_CR_SPF];
        end
    end

    // highest pending status bit, fifteen less the leading-zero count of the status word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            top_pending_reg <= 4'h0;
            pending_reg <= 1'b0;
        end else begin
            pending_reg <= |status_reg;
            top_pending_reg <= 4'h0;
            for (int b = 0; b < 16; b++) begin
                if (status_reg[b]) begin
                    top_pending_reg <= 4'(b);
                end
            end
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign redirect_o = redirect_reg;
    assign redirect_ip_o = redirect_ip_reg;
    assign exec_mask_o = exec_mask_reg;
    assign fpctl_o = fpctl_reg;
    assign exc_state_o = master_reg;
    assign top_pending_o = top_pending_reg;
    assign pending_o = pending_reg;

    // checks of the exception machinery and the masks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    exc_take_jump_a: assert property (take_exc |=> redirect_o && redirect_ip_o == $past(handler_entry_i[31:0]))
        else $error("exception did not jump to handler entry");
    resume_capture_a: assert property (take_exc |=> resume_reg == $past(ip_i))
        else $error("resume pointer not captured");
    master_set_a: assert property (take_exc |=> exc_state_o)
        else $error("master bit not set by exception");
    master_hold_a: assert property (wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W0 && acc_i.wdata[31]
        && !take_exc && !load_i |=> exc_state_o == $past(master_reg))
        else $error("writing one changed master bit");
    return_jump_a: assert property (ret_exc && !take_exc && !load_i
        |=> redirect_o && redirect_ip_o == $past(resume_reg) && !exc_state_o)
        else $error("return did not reload resume pointer");
    status_sticky_a: assert property (|exc_event_i && !load_i
        |=> (status_reg & $past(exc_event_i)) == $past(exc_event_i))
        else $error("exception event lost from status");
    group_load_a: assert property (load_i |=> gmask_reg == group_mask(channel_dispatch_mask_reg))
        else $error("grouped mask not formed from dispatch mask");
    mask_select_a: assert property (##1 exec_mask_o == ($past(ctl_reg[3]) ? $past(gmask_reg) : $past(channel_dispatch_mask_reg)))
        else $error("execution mask does not follow mask select");
    trap_off_a: assert property (!ctl_reg[9] && !load_i && !(wr && sel_sr0)
        |=> ieee_reg == $past(ieee_reg))
        else $error("float flags changed with trapping off");
    load_clear_a: assert property (load_i |=> ctl_reg[12:9] == 4'h0 && !exc_state_o)
        else $error("thread load left control bits set");
    // read answers, the reserved word and the float mode decode
    rd_answer_a: assert property (acc_i.valid && !acc_i.write |=> rd_valid_o)
        else $error("read access gave no answer");
    reserved_drop_a: assert property (wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W3 && !take_exc && !load_i
        |=> ctl_word == $past(ctl_word) && resume_reg == $past(resume_reg))
        else $error("write to reserved control word landed");
    alt_flush_a: assert property (ctl_reg[`TEC_CR_ALT] |=> !fpctl_o.sp_denorm_allow)
        else $error("single denormals allowed in alternative mode");

    take_cover_c: cover property (take_exc ##[1:20] ret_exc);
    disabled_cover_c: cover property (|exc_event_i && !take_exc);
    grouped_cover_c: cover property (ctl_reg[3] && gmask_reg != channel_dispatch_mask_reg);
    collide_cover_c: cover property (take_exc && wr && sel_cr0 && acc_i.sub_reg == `TEC_SUB_W1);
    f2i_cover_c: cover property (ctl_reg[`TEC_CR_F2I] && ctl_reg[`TEC_CR_ALT]);

endmodule
`default_nettype wire

//--- tec_map.svh
/*
 * Register selectors, field positions, write masks and reset values for the
 * thread exception control block.
 * Assumes it is included once per compilation unit by its bare name.
 */
// Contract
// - hold dispatch mask, seeds execution mask
// - grouped mask: each nibble ORs dispatch nibble
// - four fault state words kept, handler saves
// - control register type 1000b, four words
// - subregisters 00000b, 00100b, 01000b; others reserved
// - exception word bits 15:0 are enables
// - bits 31:16 record exceptions even disabled
// - exception bits ordered by decreasing priority
// - third word captures IP on exception
// - fourth word reserved, writes discarded
// - exception saves IP, sets master, jumps
// - master write rules; zero returns to resume
// - one hidden 48-bit handler pointer, low 32 used
// - bit 12 float-to-int rounding select
// - bit 11 min/max signalling NaN handling
// - bit 10 half-precision denormal mode
// - bit 9 traps float flags, no jump
// - bit 7 single denormals, ignored in alternative
// - bit 6 double-precision denormal mode
// - bits 5:4 rounding mode encoding
// - bit 3 mask select, zero picks dispatch
// - mask select one picks grouped mask
// - float flags 6:0 sticky, cleared by software/load
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

// register type and number selectors (type is the upper nibble of the register number)
`define TEC_RT_STATE 4'h7
`define TEC_RT_CTRL 4'h8
`define TEC_RN_SR0 4'h0
`define TEC_RN_SR1 4'h1
`define TEC_RN_CR0 4'h0

// subregister selectors, one per 32-bit word
`define TEC_SUB_W0 5'h00
`define TEC_SUB_W1 5'h04
`define TEC_SUB_W2 5'h08
`define TEC_SUB_W3 5'h0C

// control word field positions
`define TEC_CR_MASTER 31
`define TEC_CR_F2I 12
`define TEC_CR_MINMAX 11
`define TEC_CR_HFDEN 10
`define TEC_CR_TRAP 9
`define TEC_CR_SPDEN 7
`define TEC_CR_DPDEN 6
`define TEC_CR_RND_HI 5
`define TEC_CR_RND_LO 4
`define TEC_CR_MSEL 3
`define TEC_CR_SPF 2
`define TEC_CR_ACCDIS 1
`define TEC_CR_ALT 0

// software-writable bits of the control word, master bit handled apart
`define TEC_CR_WMASK 32'h00001EFF
// dispatcher-provided bits: 7, 6, 5:4, 3, 2, 0
`define TEC_CR_LOADMASK 32'h000000FD
`define TEC_IEEE_W 7
`define TEC_IEEE_MASK 7'h1F

// reset values
`define TEC_RST_WORD 32'h00000000
`define TEC_RST_HALF 16'h0000
`define TEC_RST_IEEE 7'h00

`endif

//--- tec_pkg.sv
/*
 * Types shared by the thread exception control block.
 * Assumes tec_map.svh carries the numeric constants.
 */
`default_nettype none
package tec_pkg;

    // rounding encodings of the two-bit rounding field
    typedef enum logic [1:0] {
        TEC_ROUND_NEAREST_EVEN = 2'h0,
        TEC_ROUND_TOWARD_PLUS_INF = 2'h1,
        TEC_ROUND_TOWARD_MINUS_INF = 2'h2,
        TEC_ROUND_TOWARD_ZERO = 2'h3
    } tec_round_type;

    // architectural operand access from the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] reg_type;
        logic [3:0] reg_num;
        logic [4:0] sub_reg;
        logic [31:0] wdata;
    } tec_access_type;

    // fields provided by the thread dispatcher on thread load
    typedef struct packed {
        logic [31:0] dispatch_mask;
        logic [31:0] ctl_init;
        logic [15:0] exc_enable;
    } tec_dispatch_type;

    // decoded float and execution controls for the datapath
    typedef struct packed {
        logic alternative_float_mode;
        logic sp_denorm_allow;
        logic dp_denorm_allow;
        logic half_float_denorm_allow;
        tec_round_type round_mode;
        tec_round_type f2i_round_mode;
        logic snan_minmax;
        logic ieee_trap_en;
        logic acc_disable;
        logic single_flow;
    } tec_fpctl_type;

endpackage
`default_nettype wire

//--- tec_pipe_model.sv
/*
 * Fetch side model for the thread exception control block: instruction
 * pointer and the global handler entry.
 * Assumes redirect pulses arrive on the same execution clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tec_pipe_model #(
    parameter logic [47:0] HANDLER = 48'hABCD_1234_5600 // arbitrary entry
) (
    input wire logic ref_clk_i, // execution clock
    input wire logic rstn_i, // async reset, active low
    input wire logic redirect_i, // fetch redirect pulse
    input wire logic [31:0] redirect_ip_i, // fetch target
    output logic [31:0] ip_o, // current instruction pointer
    output logic [47:0] handler_entry_o // global handler entry
);
    // one entry for the system; upper bits set so a wide use would show
    assign handler_entry_o = HANDLER;

    // fetch steps one slot a cycle and follows every redirect
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ip_o <= 32'h0000_0100;
        end else if (redirect_i) begin
            ip_o <= redirect_ip_i;
        end else begin
            ip_o <= ip_o + 32'h0000_0010;
        end
    end
endmodule

`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench for the thread exception control block.
 * Assumes tec_pkg and tec_map.svh are compiled first, one access per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tec_map.svh"

module testbench;
    import tec_pkg::*;
    localparam logic [47:0] HANDLER = 48'hABCD_1234_5600; // arbitrary entry
    typedef struct {logic [3:0] rt; logic [3:0] rn; logic [4:0] sub; logic [31:0] wd; logic [31:0] ex;} tec_row_type;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, load_i = 1'b0; // clock, reset, load
    tec_dispatch_type disp_i = '0; // dispatcher fields
    tec_access_type acc_i = '0; // operand access
    logic [15:0] exc_event_i = '0; // exception events
    logic [4:0] fp_flag_i = '0; // float flag pulses
    logic [31:0] ip_i, rd_data_o, redirect_ip_o, exec_mask_o, saved_ip, resume;
    logic [47:0] handler_entry_i;
    logic rd_valid_o, redirect_o, exc_state_o, pending_o;
    logic [3:0] top_pending_o;
    tec_fpctl_type fpctl_o;
    int errors = 0, compares = 0, cycles = 0;
    // write value beside the value a read-back must give
    tec_row_type rows [13] = '{
        '{4'h8, 4'h0, 5'h00, 32'hFFFF_FFFF, 32'h0000_1EFF},
        '{4'h8, 4'h0, 5'h04, 32'h1234_5678, 32'h1234_5678},
        '{4'h8, 4'h0, 5'h08, 32'h89AB_CDEF, 32'h89AB_CDEF},
        '{4'h8, 4'h0, 5'h0C, 32'hFFFF_FFFF, 32'h0000_0000},
        '{4'h8, 4'h0, 5'h10, 32'hFFFF_FFFF, 32'h0000_0000},
        '{4'h8, 4'h1, 5'h00, 32'hFFFF_FFFF, 32'h0000_0000},
        '{4'h7, 4'h0, 5'h08, 32'h0F0F_0001, 32'h0F0F_0001},
        '{4'h7, 4'h0, 5'h0C, 32'h00F0_000F, 32'h00F0_000F},
        '{4'h7, 4'h1, 5'h00, 32'hA5A5_0001, 32'hA5A5_0001},
        '{4'h7, 4'h1, 5'h04, 32'hA5A5_0002, 32'hA5A5_0002},
        '{4'h7, 4'h1, 5'h08, 32'hA5A5_0003, 32'hA5A5_0003},
        '{4'h7, 4'h1, 5'h0C, 32'hA5A5_0004, 32'hA5A5_0004},
        '{4'h7, 4'h0, 5'h04, 32'hFFFF_FFFF, 32'h0000_001F}
    };

    tec_thread_exception_control DUT (
        .ref_clk_i, .rstn_i, .load_i, .disp_i, .acc_i, .exc_event_i, .ip_i, .handler_entry_i,
        .fp_flag_i, .rd_data_o, .rd_valid_o, .redirect_o, .redirect_ip_o, .exec_mask_o,
        .fpctl_o, .exc_state_o, .top_pending_o, .pending_o
    );
    tec_pipe_model #(.HANDLER(HANDLER)) PIPE (
        .ref_clk_i, .rstn_i, .redirect_i(redirect_o), .redirect_ip_i(redirect_ip_o),
        .ip_o(ip_i), .handler_entry_o(handler_entry_i)
    );

    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // whole run is about 125 cycles; a hang runs into this ceiling
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one access: raised after an edge, dropped after the taking edge; the gap after it is the switch
    task automatic acc(input logic w, input logic [3:0] rt, input logic [3:0] rn, input logic [4:0] sub,
                       input logic [31:0] wd);
        @(posedge ref_clk_i);
        acc_i <= '{1'b1, w, rt, rn, sub, wd};
        @(posedge ref_clk_i);
        acc_i.valid <= 1'b0;
        #1;
    endtask

    // read answer stands for the single cycle after the taking edge
    task automatic rd(input logic [3:0] rt, input logic [3:0] rn, input logic [4:0] sub, input logic [31:0] ex);
        acc(1'b0, rt, rn, sub, 32'h0000_0000);
        chk({31'h0, rd_valid_o}, 32'h0000_0001);
        chk(rd_data_o, ex);
    endtask

    // ip steps every cycle in the model; sample it after the raising edge, the value the taking edge captures
    task automatic pulse_exc(input logic [15:0] ev);
        @(posedge ref_clk_i);
        exc_event_i <= ev;
        #1 saved_ip = ip_i;
        @(posedge ref_clk_i);
        exc_event_i <= 16'h0000;
        #1;
    endtask

    task automatic pulse_fp(input logic [4:0] f);
        @(posedge ref_clk_i);
        fp_flag_i <= f;
        @(posedge ref_clk_i);
        fp_flag_i <= 5'h00;
    endtask

    task automatic load(input logic [31:0] dm, input logic [31:0] ci, input logic [15:0] en);
        @(posedge ref_clk_i);
        load_i <= 1'b1;
        disp_i <= '{dm, ci, en};
        @(posedge ref_clk_i);
        load_i <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        #1;
        chk(exec_mask_o, 32'h0000_0000);
        chk({31'h0, exc_state_o}, 32'h0000_0000);
        // table of write and read-back pairs
        foreach (rows[i]) begin
            acc(1'b1, rows[i].rt, rows[i].rn, rows[i].sub, rows[i].wd);
            rd(rows[i].rt, rows[i].rn, rows[i].sub, rows[i].ex);
        end
        // load: only dispatcher bits land, grouped mask is formed
        load(32'h0000_0310, 32'h0000_1EFF, 16'h0008);
        rd(4'h8, 4'h0, 5'h00, 32'h0000_00FD);
        rd(4'h7, 4'h0, 5'h08, 32'h0000_0310);
        rd(4'h7, 4'h0, 5'h0C, 32'h0000_0FF0);
        rd(4'h7, 4'h0, 5'h04, 32'h0000_0000);
        rd(4'h7, 4'h1, 5'h04, 32'hA5A5_0002);
        chk(exec_mask_o, 32'h0000_0FF0);
        // loaded word: alternative mode hides single denormals, bits 12:9 start clear
        chk({20'h0, fpctl_o}, 32'h0000_0AF1);
        // every rounding code, float-to-int stays toward zero with bit 12 clear
        for (int r = 0; r < 4; r++) begin
            acc(1'b1, 4'h8, 4'h0, 5'h00, {26'h0, r[1:0], 4'h0});
            @(posedge ref_clk_i);
            #1;
            chk({30'h0, fpctl_o.round_mode}, {30'h0, r[1:0]});
            chk({30'h0, fpctl_o.f2i_round_mode}, {30'h0, TEC_ROUND_TOWARD_ZERO});
        end
        // mode bits set in alternative mode, then standard mode with single denormals
        acc(1'b1, 4'h8, 4'h0, 5'h00, 32'h0000_1CD3);
        @(posedge ref_clk_i);
        #1;
        chk({20'h0, fpctl_o}, 32'h0000_0B5A);
        acc(1'b1, 4'h8, 4'h0, 5'h00, 32'h0000_0080);
        @(posedge ref_clk_i);
        #1;
        chk({20'h0, fpctl_o}, 32'h0000_0430);
        chk(exec_mask_o, 32'h0000_0310);
        // a disabled event is only recorded
        pulse_exc(16'h0020);
        chk({31'h0, redirect_o}, 32'h0000_0000);
        pulse_exc(16'h0008);
        resume = saved_ip;
        chk({31'h0, redirect_o}, 32'h0000_0001);
        chk(redirect_ip_o, HANDLER[31:0]);
        chk({31'h0, exc_state_o}, 32'h0000_0001);
        rd(4'h8, 4'h0, 5'h08, resume);
        rd(4'h8, 4'h0, 5'h04, 32'h0028_0008);
        chk({28'h0, top_pending_o}, 32'h0000_0005);
        chk({31'h0, pending_o}, 32'h0000_0001);
        // a second event in handler state gives no redirect
        pulse_exc(16'h0008);
        chk({31'h0, redirect_o}, 32'h0000_0000);
        // clearing the master bit returns to the saved pointer
        acc(1'b1, 4'h8, 4'h0, 5'h00, 32'h0000_0000);
        chk({31'h0, redirect_o}, 32'h0000_0001);
        chk(redirect_ip_o, resume);
        chk({31'h0, exc_state_o}, 32'h0000_0000);
        // writing one while normal leaves the thread normal
        acc(1'b1, 4'h8, 4'h0, 5'h00, 32'h8000_0000);
        chk({31'h0, exc_state_o}, 32'h0000_0000);
        // float flags: ignored untrapped, sticky when trapped, no jump
        pulse_fp(5'h04);
        rd(4'h7, 4'h0, 5'h04, 32'h0000_0000);
        acc(1'b1, 4'h8, 4'h0, 5'h00, 32'h0000_0200);
        pulse_fp(5'h04);
        pulse_fp(5'h01);
        rd(4'h7, 4'h0, 5'h04, 32'h0000_0005);
        chk({31'h0, exc_state_o}, 32'h0000_0000);
        load(32'h0000_0001, 32'h0000_0000, 16'h0000);
        rd(4'h7, 4'h0, 5'h04, 32'h0000_0000);
        finish_test();
    end
endmodule

`default_nettype wire
